/* hdl/scru_core.sv */
// Purpose: Command decoder and response reporter of the sensor sequencer
// Assumes: Command, mailbox and overflow inputs come from logic on clk_sys
// Notes:   Response counter wraps; errors hold until cleared
`timescale 1ns/1ps
`default_nettype none
`include "scru_defs.svh"

module scru_core
   import scru_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Command and mailbox from the bus front end
   input  wire scru_cmd_t  cmd,
   input  wire logic [7:0] write_mailbox,
   // Overflow pulses from conversions
   input  wire scru_ovf_t  ovf,
   // Host-visible results
   output logic [7:0]      response,
   output logic [7:0]      read_mailbox,
   output logic [6:0]      bus_address,
   // Sequencer control
   output scru_meas_t      meas,
   output logic            wake,
   output logic            soft_reset,
   output logic            busy
);

   // Whole module state
   typedef struct packed {
      scru_state_t state;      // Execution state
      logic [1:0]  op;         // Parameter operation group low bits
      logic [4:0]  addr;       // Parameter address
      logic [7:0]  response;   // Response register
      logic [7:0]  rmail;      // Read mailbox
      logic [6:0]  bus_addr;   // Slave address
      scru_meas_t  meas;       // Measurement control
      logic        wake;       // Wake pulse
      logic        soft_reset; // Firmware reset pulse
   } scru_core_st_t;

   scru_core_st_t st;         // Registered state
   scru_core_st_t next_st;    // Next state
   logic [7:0]    ram_rdata;  // Parameter read data
   logic          ram_we;     // Parameter write strobe
   logic [7:0]    ram_wdata;  // Parameter write data
   logic [4:0]    ram_addr;   // Parameter address

   ////////////////////////////////////////////////////////////////////////////
   // Parameter store
   // Read data lag the address by one cycle, so a
   // parameter command spends one cycle waiting for it
   scru_param_ram #(.DEPTH(32), .AW(5)) u_ram (
      .clk_sys (clk_sys),
      .reset   (reset),
      .addr    (ram_addr),
      .wr_en   (ram_we),
      .wr_data (ram_wdata),
      .rd_data (ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   // Pulses fall back to zero each cycle so they stand
   // for one cycle only; levels keep their value
   always_comb begin
      next_st = st;
      next_st.meas.prox_single = 1'b0;
      next_st.meas.amb_single  = 1'b0;
      next_st.wake       = 1'b0;
      next_st.soft_reset = 1'b0;
      ram_we    = 1'b0;
      ram_wdata = write_mailbox;
      // Address follows the command while idle so the read
      // starts in the cycle the command is taken
      ram_addr  = (st.state == SCRU_IDLE) ? cmd.code[4:0] : st.addr;

      unique case (st.state)
         SCRU_IDLE: begin
            // Only command writes wake the sequencer
            if (cmd.valid) begin
               next_st.wake = 1'b1;
               if (cmd.code[7]) begin
                  // Parameter commands read first
                  next_st.addr  = cmd.code[4:0];
                  next_st.op    = cmd.code[6:5];
                  next_st.state = SCRU_PREAD;
               end else if (cmd.code[6:5] != 2'h0) begin
                  // Groups 001-011 are reserved
                  next_st.response = `SCRU_RSP_INVALID_SETTING;
               end else begin
                  unique case (cmd.code[4:0])
                     `SCRU_CMD_CLEAR_RESPONSE: begin
                        next_st.response = `SCRU_RESET_RESPONSE;
                     end
                     `SCRU_CMD_SOFT_RESET: begin
                        // Sequencer restarts; response not counted
                        next_st.soft_reset = 1'b1;
                        next_st.meas.prox_loop = 1'b0;
                        next_st.meas.amb_loop  = 1'b0;
                     end
                     `SCRU_CMD_BUS_ADDRESS: begin
                        // New address from the mailbox, never an error
                        next_st.bus_addr = write_mailbox[6:0];
                     end
                     `SCRU_CMD_PROX_SINGLE, `SCRU_CMD_AMB_SINGLE,
                     `SCRU_CMD_BOTH_SINGLE: begin
                        next_st.meas.prox_single = cmd.code[0];
                        next_st.meas.amb_single  = cmd.code[1];
                     end
                     `SCRU_CMD_PROX_HALT, `SCRU_CMD_AMB_HALT,
                     `SCRU_CMD_BOTH_HALT: begin
                        if (cmd.code[0]) next_st.meas.prox_loop = 1'b0;
                        if (cmd.code[1]) next_st.meas.amb_loop  = 1'b0;
                     end
                     `SCRU_CMD_PROX_LOOP, `SCRU_CMD_AMB_LOOP,
                     `SCRU_CMD_BOTH_LOOP: begin
                        if (cmd.code[0]) next_st.meas.prox_loop = 1'b1;
                        if (cmd.code[1]) next_st.meas.amb_loop  = 1'b1;
                     end
                     default: begin
                        // Reserved system codes
                        next_st.response = `SCRU_RSP_INVALID_SETTING;
                     end
                  endcase
                  // Measurement codes bump the counter unless an error holds
                  if (cmd.code[4:0] != `SCRU_CMD_CLEAR_RESPONSE &&
                      cmd.code[4:0] != `SCRU_CMD_SOFT_RESET &&
                      cmd.code[4:0] != `SCRU_CMD_BUS_ADDRESS &&
                      cmd.code[4:0] != 5'h03 && cmd.code[4:0] != 5'h04 &&
                      cmd.code[4:0] != 5'h08 && cmd.code[4:0] != 5'h0c &&
                      !cmd.code[4] && !st.response[7]) begin
                     next_st.response = {4'h0, st.response[3:0] + 4'h1};
                  end
               end
            end
         end
         SCRU_PREAD: begin
            // Read data now valid in ram_rdata next cycle
            next_st.state = SCRU_PWB;
         end
         SCRU_PWB: begin
            // Combine and write back
            unique case (st.op)
               2'h0: ram_wdata = ram_rdata;
               2'h1: ram_wdata = write_mailbox;
               2'h2: ram_wdata = ram_rdata & write_mailbox;
               2'h3: ram_wdata = ram_rdata | write_mailbox;
            endcase
            ram_we = (st.op != 2'h0);
            next_st.rmail = ram_wdata;
            if (!st.response[7]) begin
               next_st.response = {4'h0, st.response[3:0] + 4'h1};
            end
            next_st.state = SCRU_IDLE;
         end
         default: next_st.state = SCRU_IDLE;
      endcase

      // Overflow codes overwrite and hold; lowest channel wins
      // Written last so an overflow beats a command result
      if (ovf.aux)        next_st.response = `SCRU_RSP_AUX_OVF;
      if (ovf.infrared)   next_st.response = `SCRU_RSP_INFRARED_OVF;
      if (ovf.visible)    next_st.response = `SCRU_RSP_VISIBLE_OVF;
      if (ovf.prox_three) next_st.response = `SCRU_RSP_PROX_THREE_OVF;
      if (ovf.prox_two)   next_st.response = `SCRU_RSP_PROX_TWO_OVF;
      if (ovf.prox_one)   next_st.response = `SCRU_RSP_PROX_ONE_OVF;
      // Errors hold through other commands
      if (st.response[7] && next_st.response == {4'h0, next_st.response[3:0]} &&
          !(st.state == SCRU_IDLE && cmd.valid && cmd.code == 8'h00)) begin
         next_st.response = st.response;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   // Synchronous reset puts every field to its reset value
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st.state      <= SCRU_IDLE;
         st.op         <= 2'h0;
         st.addr       <= 5'h00;
         st.response   <= `SCRU_RESET_RESPONSE;
         st.rmail      <= `SCRU_RESET_MAILBOX;
         st.bus_addr   <= `SCRU_RESET_BUS_ADDRESS;
         st.meas       <= '0;
         st.wake       <= 1'b0;
         st.soft_reset <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign response     = st.response;
   assign read_mailbox = st.rmail;
   assign bus_address  = st.bus_addr;
   assign meas         = st.meas;
   assign wake         = st.wake;
   assign soft_reset   = st.soft_reset;
   // Busy comes straight from the state so a command in
   // the same cycle is refused without a register delay
   assign busy         = (st.state != SCRU_IDLE);

endmodule
`default_nettype wire

/* hdl/scru_defs.svh */
// Purpose: Constants for the sensor command and response unit
// Assumes: 8-bit command, response and mailbox values
// Notes:   Groups, codes and reset values only; no logic
`ifndef SCRU_DEFS_SVH
`define SCRU_DEFS_SVH

// Command group in bits [7:5]
`define SCRU_GRP_SYSTEM          3'h0
`define SCRU_GRP_PARAM_READ      3'h4
`define SCRU_GRP_PARAM_WRITE     3'h5
`define SCRU_GRP_PARAMETER_BITWISE_AND_CMD       3'h6
`define SCRU_GRP_PARAMETER_BITWISE_OR_CMD        3'h7

// System command codes in bits [4:0]
`define SCRU_CMD_CLEAR_RESPONSE  5'h00
`define SCRU_CMD_SOFT_RESET      5'h01
`define SCRU_CMD_BUS_ADDRESS     5'h02
`define SCRU_CMD_PROX_SINGLE     5'h05
`define SCRU_CMD_AMB_SINGLE      5'h06
`define SCRU_CMD_BOTH_SINGLE     5'h07
`define SCRU_CMD_PROX_HALT       5'h09
`define SCRU_CMD_AMB_HALT        5'h0a
`define SCRU_CMD_BOTH_HALT       5'h0b
`define SCRU_CMD_PROX_LOOP       5'h0d
`define SCRU_CMD_AMB_LOOP        5'h0e
`define SCRU_CMD_BOTH_LOOP       5'h0f

// Response codes
`define SCRU_RSP_INVALID_SETTING 8'h80
`define SCRU_RSP_PROX_ONE_OVF    8'h88
`define SCRU_RSP_PROX_TWO_OVF    8'h89
`define SCRU_RSP_PROX_THREE_OVF  8'h8a
`define SCRU_RSP_VISIBLE_OVF     8'h8c
`define SCRU_RSP_INFRARED_OVF    8'h8d
`define SCRU_RSP_AUX_OVF         8'h8e

// Reset values
`define SCRU_RESET_RESPONSE      8'h00
`define SCRU_RESET_MAILBOX       8'h00
`define SCRU_RESET_PARAM         8'h00
`define SCRU_RESET_BUS_ADDRESS   7'h2a

`endif

/* hdl/scru_pkg.sv */
// Purpose: Types for the sensor command and response unit
// Assumes: Constants live in scru_defs.svh
// Notes:   Packed structs carry grouped signals
package scru_pkg;

   // Command request from the bus front end
   typedef struct packed {
      logic       valid;   // One-cycle write to the command register
      logic [7:0] code;    // Command code
   } scru_cmd_t;

   // Measurement control toward the sequencer
   typedef struct packed {
      logic prox_single;   // One proximity pass pulse
      logic amb_single;    // One ambient pass pulse
      logic prox_loop;     // Autonomous proximity enabled
      logic amb_loop;      // Autonomous ambient enabled
   } scru_meas_t;

   // Overflow pulses from conversion channels
   typedef struct packed {
      logic prox_one;
      logic prox_two;
      logic prox_three;
      logic visible;
      logic infrared;
      logic aux;
   } scru_ovf_t;

   // Execution states
   typedef enum logic [1:0] {
      SCRU_IDLE  = 2'b00,  // Waiting for a command
      SCRU_PREAD = 2'b01,  // Parameter read data pending
      SCRU_PWB   = 2'b10   // Write back parameter result
   } scru_state_t;

endpackage

/* hdl/scru_param_ram.sv */
// Purpose: Parameter store of 32 bytes with registered read data
// Assumes: One write or one read per cycle
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "scru_defs.svh"

module scru_param_ram #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          reset,
   // Access
   input  wire logic [AW-1:0] addr,
   input  wire logic          wr_en,
   input  wire logic [7:0]    wr_data,
   output logic      [7:0]    rd_data
);

   logic [7:0] mem [DEPTH];   // Parameter bytes

   ////////////////////////////////////////////////////////////////////////////
   // Write port and registered read, cleared on reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= `SCRU_RESET_PARAM;
         end
         rd_data <= `SCRU_RESET_PARAM;
      end else begin
         if (wr_en) begin
            mem[addr] <= wr_data;
         end
         rd_data <= mem[addr];
      end
   end

endmodule
`default_nettype wire

/* bench/scru_core_asserts.sv */
// Purpose: Port checks for the command and response unit
// Assumes: Sees only scru_core ports, one clock domain
// Notes:   Bound to scru_core below the module
`timescale 1ns/1ps
`default_nettype none
module scru_core_asserts
   import scru_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Inputs
   input wire scru_cmd_t  cmd,
   input wire logic [7:0] write_mailbox,
   input wire scru_ovf_t  ovf,
   // Outputs
   input wire logic [7:0] response,
   input wire logic [7:0] read_mailbox,
   input wire logic [6:0] bus_address,
   input wire scru_meas_t meas,
   input wire logic       wake,
   input wire logic       soft_reset,
   input wire logic       busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic acc;  // Command taken
   logic q;    // Taken, no overflow
   logic rsv;  // Reserved code
   logic ok;   // Counting system code
   assign acc = cmd.valid && !busy;
   assign q = acc && ovf == 6'h00;
   assign rsv = cmd.code[7:5] inside {3'h1, 3'h2, 3'h3} || cmd.code[7:4] == 4'h1
      || cmd.code inside {8'h03, 8'h04, 8'h08, 8'h0c};
   assign ok = cmd.code inside {8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0d,
      8'h0e, 8'h0f};
   // Parameter run: two busy cycles then free
   sequence s_run;
      busy [*2] ##1 !busy;
   endsequence
   property p_wake; acc |=> wake; endproperty
   property p_nowake; !acc |=> !wake; endproperty
   property p_clr; q && cmd.code == 8'h00 |=> response == 8'h00; endproperty
   property p_cnt; q && ok && !response[7] |=>
      response == {4'h0, $past(response[3:0]) + 4'h1}; endproperty
   property p_err; q && rsv |=> response == 8'h80 && !meas.prox_single
      && !meas.amb_single; endproperty
   property p_hold; response[7] && !acc && !busy && ovf == 6'h00 |=>
      $stable(response); endproperty
   property p_prox; ovf.prox_one |=> response == 8'h88; endproperty
   property p_aux; ovf == 6'h01 |=> response == 8'h8e; endproperty
   property p_one; acc && cmd.code == 8'h07 |=> meas.prox_single && meas.amb_single;
   endproperty
   property p_srst; acc && cmd.code == 8'h01 |=> soft_reset; endproperty
   property p_param; acc && cmd.code[7] |=> s_run; endproperty
   property p_addr; q && cmd.code == 8'h02 |=>
      bus_address == $past(write_mailbox[6:0]) && $stable(response); endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   a_nowake: assert property (p_nowake) else $error("stray wake");
   a_clr: assert property (p_clr) else $error("no clear");
   a_cnt: assert property (p_cnt) else $error("bad count");
   a_err: assert property (p_err) else $error("bad invalid");
   a_hold: assert property (p_hold) else $error("error moved");
   a_prox: assert property (p_prox) else $error("bad prox ovf");
   a_aux: assert property (p_aux) else $error("bad aux ovf");
   a_one: assert property (p_one) else $error("no pass");
   a_srst: assert property (p_srst) else $error("no soft reset");
   a_param: assert property (p_param) else $error("bad busy");
   a_addr: assert property (p_addr) else $error("bad address");
endmodule
bind scru_core scru_core_asserts u_chk (.clk_sys, .reset, .cmd, .write_mailbox,
   .ovf, .response, .read_mailbox, .bus_address, .meas, .wake, .soft_reset, .busy);
`default_nettype wire

/* bench/scru_host.sv */
// Purpose: Host model writing commands to the unit
// Assumes: Outputs move 1 ns after a rising edge
// Notes:   Caller keeps parameter command spacing
`timescale 1ns/1ps
`default_nettype none
module scru_host
   import scru_pkg::*;
(
   // Clock
   input wire logic        clk_sys,
   // To the unit
   output var scru_cmd_t   cmd,
   output var logic [7:0]  write_mailbox,
   // From the unit
   input wire logic [7:0]  response
);
   initial begin
      cmd = '0;
      write_mailbox = 8'h00;
   end
   // One command write, held over one edge
   task automatic send(input logic [7:0] c, w);
      @(posedge clk_sys);
      #1;
      cmd = {1'b1, c};
      write_mailbox = w;
      @(posedge clk_sys);
      #1;
      cmd.valid = 1'b0;
   endtask
   localparam int QUIET_CYCLES = 40000;  // 1 ms of clk_sys at 25 ns
   // Hold off further commands after a firmware reset
   task automatic quiet;
      repeat (QUIET_CYCLES) @(posedge clk_sys);
      #1;
   endtask
   // Clear, confirm zero, write, poll bounded
   task automatic run(input logic [7:0] c, w, output logic good);
      int n;
      send(8'h00, 8'h00);
      good = response === 8'h00;
      send(c, w);
      n = 0;
      while (response === 8'h00 && n < 8) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      good = good && response !== 8'h00;
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for scru_core
// Assumes: Host model drives commands, bench drives overflow
// Notes:   Run is about 40100 cycles, mostly quiet time after firmware reset
`timescale 1ns/1ps
`default_nettype none
module tb;
   import scru_pkg::*;
   logic       clk_sys = 1'b0;
   logic       reset = 1'b1;
   scru_ovf_t  ovf = '0;
   scru_cmd_t  cmd;
   scru_meas_t meas, em;
   logic [7:0] wm, response, rmb;
   logic [6:0] addr;
   logic       wake, srst, busy, ok;
   int         fails = 0;
   int         n_tests = 0;
   logic [7:0] tab [9] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h0f};
   logic [7:0] rsv [8] = '{8'h03, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1f, 8'h20, 8'h7f};
   logic [7:0] oc [6] = '{8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d, 8'h8e};
   always #12.5 clk_sys = ~clk_sys;
   scru_host host (.clk_sys, .cmd, .write_mailbox(wm), .response);
   scru_core dut (.clk_sys, .reset, .cmd, .write_mailbox(wm), .ovf, .response,
      .read_mailbox(rmb), .bus_address(addr), .meas, .wake, .soft_reset(srst), .busy);
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic tick;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      chk(response, 8'h00, "rsp");
      chk({1'b0, addr}, 8'h2a, "adr");
      chk({4'h0, meas}, 8'h00, "meas");
      chk(rmb, 8'h00, "rmb");
      chk({7'h0, busy}, 8'h00, "busy");
      chk({7'h0, wake}, 8'h00, "wake");
      chk({7'h0, srst}, 8'h00, "srst");
      $display("t_reset done");
   endtask
   // Every counting code, counter wraps
   task automatic t_count;
      logic [7:0] c;
      host.send(8'h00, 8'h00);
      chk(response, 8'h00, "clr");
      em = '0;
      for (int i = 0; i < 18; i++) begin
         c = tab[i % 9];
         host.send(c, 8'h00);
         em.prox_single = c inside {8'h05, 8'h07};
         em.amb_single = c inside {8'h06, 8'h07};
         em.prox_loop = c inside {8'h0d, 8'h0f} || em.prox_loop && !(c inside {8'h09, 8'h0b});
         em.amb_loop = c inside {8'h0e, 8'h0f} || em.amb_loop && !(c inside {8'h0a, 8'h0b});
         chk({4'h0, meas}, {4'h0, em}, "meas");
         chk({7'h0, wake}, 8'h01, "wake");
         chk(response, {4'h0, 4'(i + 1)}, "cnt");
      end
      $display("t_count done");
   endtask
   // Set, OR, AND, query, command while busy
   task automatic t_param;
      host.send(8'h00, 8'h00);
      host.send(8'ha3, 8'h5a);
      chk({7'h0, busy}, 8'h01, "busy1");
      host.send(8'h03, 8'h5a);
      chk({7'h0, wake}, 8'h00, "nowake");
      chk(response, 8'h01, "busy");
      chk(rmb, 8'h5a, "set");
      host.send(8'he3, 8'h81);
      tick;
      chk(rmb, 8'hdb, "or");
      host.send(8'hc3, 8'h0f);
      tick;
      chk(rmb, 8'h0b, "and");
      host.send(8'h83, 8'hff);
      tick;
      chk(rmb, 8'h0b, "qry");
      host.send(8'hff, 8'h0f);
      tick;
      chk(rmb, 8'h0f, "or31");
      chk(response, 8'h05, "cnt");
      $display("t_param done");
   endtask
   // Reserved codes, error held until clear
   task automatic t_err;
      for (int i = 0; i < 8; i++) begin
         host.send(8'h00, 8'h00);
         host.send(rsv[i], 8'h00);
         chk({6'h0, meas.prox_single, meas.amb_single}, 8'h00, "meas");
         chk(response, 8'h80, "inv");
      end
      host.send(8'h05, 8'h00);
      chk(response, 8'h80, "held");
      host.send(8'h00, 8'h00);
      chk(response, 8'h00, "clr");
      $display("t_err done");
   endtask
   // Each overflow, then one against a command
   task automatic t_ovf;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         #1;
         ovf = 6'h20 >> i;
         @(posedge clk_sys);
         #1;
         ovf = '0;
         chk(response, oc[i], "ovf");
      end
      host.send(8'h00, 8'h00);
      fork
         host.send(8'h05, 8'h00);
         begin
            @(posedge clk_sys);
            #1;
            ovf = 6'h01;
            @(posedge clk_sys);
            #1;
            ovf = '0;
         end
      join
      chk(response, 8'h8e, "beat");
      host.send(8'h00, 8'h00);
      $display("t_ovf done");
   endtask
   // Soft reset, address change, host sequence
   task automatic t_sys;
      host.send(8'h0f, 8'h00);
      host.send(8'h01, 8'h00);
      chk({7'h0, srst}, 8'h01, "srst");
      chk({4'h0, meas}, 8'h00, "loops");
      host.quiet;
      host.send(8'h02, 8'hb3);
      chk({1'b0, addr}, 8'h33, "adr");
      chk(response, 8'h01, "noerr");
      host.run(8'h06, 8'h00, ok);
      chk({7'h0, ok}, 8'h01, "proto");
      $display("t_sys done");
   endtask
   // Reset in mid-run clears results and the parameter store
   task automatic t_midreset;
      @(posedge clk_sys);
      #1;
      reset = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset;
      host.send(8'h83, 8'h00);
      tick;
      chk(rmb, 8'h00, "ram clr");
      chk(response, 8'h01, "cnt");
      $display("t_midreset done");
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset;
      t_count;
      t_param;
      t_err;
      t_ovf;
      t_sys;
      t_midreset;
      test_done;
   end
   // Watchdog, about twice the expected run
   initial begin
      #2ms;
      fails++;
      test_done;
   end
endmodule
`default_nettype wire
